// [logic/cep_pkg.sv]
// Constants, register map and types for the exception prioritizer
package cep_pkg;
  localparam logic [31:0] CEP_VEC_BOOT      = 32'hbfc0_0000;
  localparam logic [31:0] CEP_VEC_DBG_NOPRB = 32'hbfc0_0480;
  localparam logic [31:0] CEP_VEC_DBG_PRB   = 32'hbfc0_0200;
  localparam logic [31:0] CEP_GEN_OFS       = 32'h0000_0180;
  localparam logic [31:0] CEP_EXCEPTION_BASE_RST     = 32'h9fc0_0000;
  localparam logic [31:0] CEP_STATUS_RST    = 32'h0040_0004;
  localparam logic [4:0]  CEP_CC_INT        = 5'h00;
  localparam logic [4:0]  CEP_CC_LOAD_MISALIGN_FAULT       = 5'h04;
  localparam logic [4:0]  CEP_CC_IBE        = 5'h06;
  localparam logic [4:0]  CEP_CC_SYS        = 5'h08;
  localparam logic [4:0]  CEP_CC_BRK        = 5'h09;
  localparam int          CEP_MULTI_VECTOR_MODE_BIT      = 12;
  localparam int          CEP_SS_W          = 4;
  localparam logic [3:0]  CEP_SS_ONE        = 4'h1;
  // Register addresses
  localparam logic [3:0]  CEP_A_INTCTL      = 4'h0;
  localparam logic [3:0]  CEP_A_PRIORITY_SHADOW_SELECT       = 4'h1;
  localparam logic [3:0]  CEP_A_DBGCTL      = 4'h2;
  localparam logic [3:0]  CEP_A_STATUS      = 4'h3;
  localparam logic [3:0]  CEP_A_CAUSE       = 4'h4;
  localparam logic [3:0]  CEP_A_EXCEPTION_BASE       = 4'h5;
  localparam logic [3:0]  CEP_A_IRQST       = 4'h6;
  localparam logic [3:0]  CEP_A_IRQMSK      = 4'h7;
  // Status bit positions
  localparam int          CEP_ST_ERL        = 2;
  localparam int          CEP_ST_EXL        = 1;
  localparam int          CEP_ST_NMI        = 19;
  localparam int          CEP_ST_SR         = 20;
  localparam int          CEP_ST_BEV        = 22;
  localparam int          CEP_ST_IPL        = 10;
  // Debug control bit positions
  localparam int          CEP_DC_BRK        = 12;
  localparam int          CEP_DC_PRB        = 15;
  typedef enum logic [3:0] {
    CEP_X_NONE, CEP_X_RST, CEP_X_SRST, CEP_X_DSS, CEP_X_DEBUG_INTERRUPT, CEP_X_NMI, CEP_X_INT,
    CEP_X_DIB, CEP_X_LOAD_MISALIGN_FAULT, CEP_X_IBE, CEP_X_DBP, CEP_X_SYS, CEP_X_BRK
  } cep_exc_t;
endpackage

// [logic/cep_prioritizer.sv]
// Exception recognition, prioritisation and vectoring unit
`timescale 1ns/1ps
module cep_prioritizer
  import cep_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // Exception sources
  input  wire logic        master_clear_input,
  input  wire logic        soft_reset_req,
  input  wire logic        debug_single_step,
  input  wire logic        nmi_req,
  input  wire logic        int_req,
  input  wire logic [2:0]  int_level,
  input  wire logic        debug_instruction_break,
  input  wire logic        load_misalign_fault,
  input  wire logic        fetch_bus_fault,
  input  wire logic        debug_breakpoint_instruction,
  input  wire logic        system_call_instruction,
  input  wire logic        break_fault,
  input  wire logic [2:0]  ext_irq_pin,
  // Taken exception
  output logic             exc_take,
  output logic [31:0]      exc_vector,
  output logic [4:0]       cause_code,
  output logic [3:0]       exc_kind,
  output logic [5:0]       debug_cause,
  output logic             shadow_set,
  output logic [2:0]       ext_irq_edge,
  output logic             irq,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  logic [31:0] intctl_q, priority_shadow_select_q, dbgctl_q, status_q, exception_base_q;
  logic [4:0]  cause_q;
  logic [2:0]  irqst_q, irqmsk_q;
  logic [2:0]  pin_s1_q, pin_s2_q, pin_d_q;
  logic        master_clear_input_s1_q, master_clear_input_s2_q;
  logic [2:0]  edge_d;
  cep_exc_t    sel_d;
  logic        dbg_brk_d;
  logic [31:0] vec_d;
  logic [4:0]  cc_d;
  logic        ss_d;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pin_s1_q  <= 3'h0;
      pin_s2_q  <= 3'h0;
      pin_d_q   <= 3'h0;
      master_clear_input_s1_q <= 1'b0;
      master_clear_input_s2_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1_q  <= ext_irq_pin;
      pin_s2_q  <= pin_s1_q;
      pin_d_q   <= pin_s2_q;
      master_clear_input_s1_q <= master_clear_input;
      master_clear_input_s2_q <= master_clear_input_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_edge
      assign edge_d[g] = intctl_q[g] ? (pin_s2_q[g] & ~pin_d_q[g])
                                     : (~pin_s2_q[g] & pin_d_q[g]);
      property p_edge;
        @(posedge clk_sys) disable iff (!rstn)
        (intctl_q[g] ? $rose(pin_s2_q[g]) : $fell(pin_s2_q[g])) |-> edge_d[g];
      endproperty
      a_edge: assert property (p_edge) else $error("selected pin edge missed");
    end
  endgenerate
  assign ext_irq_edge = edge_d;

  //////////////////////////////////////////////////////////////////////////
  // Priority selection
  assign dbg_brk_d = dbgctl_q[CEP_DC_BRK];

  always_comb
  begin
    if (master_clear_input_s2_q)                         sel_d = CEP_X_RST;
    else if (soft_reset_req)               sel_d = CEP_X_SRST;
    else if (debug_single_step)            sel_d = CEP_X_DSS;
    else if (dbg_brk_d)                    sel_d = CEP_X_DEBUG_INTERRUPT;
    else if (nmi_req)                      sel_d = CEP_X_NMI;
    else if (int_req)                      sel_d = CEP_X_INT;
    else if (debug_instruction_break)      sel_d = CEP_X_DIB;
    else if (load_misalign_fault)          sel_d = CEP_X_LOAD_MISALIGN_FAULT;
    else if (fetch_bus_fault)              sel_d = CEP_X_IBE;
    else if (debug_breakpoint_instruction) sel_d = CEP_X_DBP;
    else if (system_call_instruction)      sel_d = CEP_X_SYS;
    else if (break_fault)                  sel_d = CEP_X_BRK;
    else                                   sel_d = CEP_X_NONE;
  end

  // Vector and cause for the winner
  always_comb
  begin
    vec_d = exception_base_q + CEP_GEN_OFS;
    cc_d  = cause_q;
    ss_d  = 1'b0;
    case (sel_d)
      CEP_X_RST, CEP_X_SRST, CEP_X_NMI: vec_d = CEP_VEC_BOOT;
      CEP_X_DSS, CEP_X_DEBUG_INTERRUPT, CEP_X_DIB, CEP_X_DBP:
        vec_d = dbgctl_q[CEP_DC_PRB] ? CEP_VEC_DBG_PRB : CEP_VEC_DBG_NOPRB;
      CEP_X_INT:
      begin
        cc_d = CEP_CC_INT;
        if (intctl_q[CEP_MULTI_VECTOR_MODE_BIT])
          ss_d = (priority_shadow_select_q[int_level*CEP_SS_W +: CEP_SS_W] == CEP_SS_ONE);
      end
      CEP_X_LOAD_MISALIGN_FAULT: cc_d = CEP_CC_LOAD_MISALIGN_FAULT;
      CEP_X_IBE:  cc_d = CEP_CC_IBE;
      CEP_X_SYS:  cc_d = CEP_CC_SYS;
      CEP_X_BRK:  cc_d = CEP_CC_BRK;
      default:    vec_d = exception_base_q + CEP_GEN_OFS;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Taken exception outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      exc_take    <= 1'b0;
      exc_vector  <= CEP_VEC_BOOT;
      cause_code  <= 5'h00;
      exc_kind    <= 4'h0;
      debug_cause <= 6'h00;
      shadow_set  <= 1'b0;
    end
    else if (clk_en)
    begin
      exc_take   <= (sel_d != CEP_X_NONE);
      exc_vector <= vec_d;
      cause_code <= cc_d;
      exc_kind   <= sel_d;
      shadow_set <= ss_d;
      case (sel_d)
        CEP_X_DSS:  debug_cause <= 6'h01;
        CEP_X_DEBUG_INTERRUPT: debug_cause <= 6'h02;
        CEP_X_DIB:  debug_cause <= 6'h04;
        CEP_X_DBP:  debug_cause <= 6'h08;
        default:    debug_cause <= 6'h00;
      endcase
    end
  end

  property p_dss;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_DSS && !dbgctl_q[CEP_DC_PRB])
      |=> (exc_vector == CEP_VEC_DBG_NOPRB && debug_cause == 6'h01);
  endproperty
  a_dss: assert property (p_dss) else $error("single step vector wrong");

  property p_dbp;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_DBP) |=> (debug_cause == 6'h08 && exc_kind == CEP_X_DBP);
  endproperty
  a_dbp: assert property (p_dbp) else $error("breakpoint flag not set");

  property p_ss7;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_INT && intctl_q[CEP_MULTI_VECTOR_MODE_BIT] && int_level == 3'h7
      && priority_shadow_select_q[7*CEP_SS_W +: CEP_SS_W] == CEP_SS_ONE) |=> shadow_set;
  endproperty
  a_ss7: assert property (p_ss7) else $error("level 7 shadow set not used");

  //////////////////////////////////////////////////////////////////////////
  // Status and cause registers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      status_q <= CEP_STATUS_RST;
      cause_q  <= 5'h00;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == CEP_A_STATUS)
        status_q <= reg_wdata;
      case (sel_d)
        CEP_X_RST:
        begin
          status_q[CEP_ST_BEV] <= 1'b1;
          status_q[CEP_ST_ERL] <= 1'b1;
        end
        CEP_X_SRST:
        begin
          status_q[CEP_ST_BEV] <= 1'b1;
          status_q[CEP_ST_SR]  <= 1'b1;
          status_q[CEP_ST_ERL] <= 1'b1;
        end
        CEP_X_NMI:
        begin
          status_q[CEP_ST_BEV] <= 1'b1;
          status_q[CEP_ST_NMI] <= 1'b1;
          status_q[CEP_ST_ERL] <= 1'b1;
        end
        CEP_X_INT: status_q[CEP_ST_IPL +: 3] <= int_level;
        CEP_X_LOAD_MISALIGN_FAULT, CEP_X_IBE, CEP_X_SYS, CEP_X_BRK:
          status_q[CEP_ST_EXL] <= 1'b1;
        default: ;
      endcase
      cause_q <= cc_d;
    end
  end

  property p_srst;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_SRST) |=> (exc_vector == CEP_VEC_BOOT && status_q[CEP_ST_BEV]
      && status_q[CEP_ST_SR] && status_q[CEP_ST_ERL]);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset entry wrong");

  property p_nmi;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_NMI) |=> (exc_vector == CEP_VEC_BOOT && status_q[CEP_ST_BEV]
      && status_q[CEP_ST_NMI] && status_q[CEP_ST_ERL]);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi entry wrong");

  property p_brk;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_BRK) |=> (cause_code == CEP_CC_BRK && status_q[CEP_ST_EXL]
      && exc_vector == $past(exception_base_q) + CEP_GEN_OFS);
  endproperty
  a_brk: assert property (p_brk) else $error("break entry wrong");

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      intctl_q <= 32'h0;
      priority_shadow_select_q  <= 32'h0;
      dbgctl_q <= 32'h0;
      exception_base_q  <= CEP_EXCEPTION_BASE_RST;
      irqmsk_q <= 3'h0;
    end
    else if (clk_en)
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          CEP_A_INTCTL: intctl_q <= reg_wdata;
          CEP_A_PRIORITY_SHADOW_SELECT:  priority_shadow_select_q  <= reg_wdata;
          CEP_A_DBGCTL: dbgctl_q <= reg_wdata;
          CEP_A_EXCEPTION_BASE:  exception_base_q  <= {reg_wdata[31:12], 12'h000};
          CEP_A_IRQMSK: irqmsk_q <= reg_wdata[2:0];
          default: ;
        endcase
      end
      if (sel_d == CEP_X_DEBUG_INTERRUPT)
        dbgctl_q[CEP_DC_BRK] <= 1'b0;
    end
  end

  property p_freeze;
    @(posedge clk_sys) disable iff (!rstn)
    !clk_en |=> ($stable(exc_vector) && $stable(status_q) && $stable(dbgctl_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: edges set, write one clears, set wins
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      irqst_q <= 3'h0;
    else if (clk_en)
      irqst_q <= (irqst_q & ~((reg_wr && reg_addr == CEP_A_IRQST) ? reg_wdata[2:0] : 3'h0))
                 | edge_d;
  end
  assign irq = |(irqst_q & irqmsk_q);

  property p_irq_set;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && edge_d != 3'h0) |=> ((irqst_q & $past(edge_d)) == $past(edge_d));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("pin edge did not set status");

  //////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          CEP_A_INTCTL: reg_rdata <= intctl_q;
          CEP_A_PRIORITY_SHADOW_SELECT:  reg_rdata <= priority_shadow_select_q;
          CEP_A_DBGCTL: reg_rdata <= dbgctl_q;
          CEP_A_STATUS: reg_rdata <= status_q;
          CEP_A_CAUSE:  reg_rdata <= {25'h0, cause_q, 2'h0};
          CEP_A_EXCEPTION_BASE:  reg_rdata <= exception_base_q;
          CEP_A_IRQST:  reg_rdata <= {29'h0, irqst_q};
          CEP_A_IRQMSK: reg_rdata <= {29'h0, irqmsk_q};
          default:      reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  property p_rd_cause;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && reg_rd && reg_addr == CEP_A_CAUSE) |=> (reg_rdata[6:2] == $past(cause_q));
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("cause field not readable");

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rst_vec;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && master_clear_input_s2_q) |=> (exc_vector == CEP_VEC_BOOT && exc_kind == CEP_X_RST);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset not vectored to boot");

  property p_prio;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && nmi_req && !master_clear_input_s2_q && !soft_reset_req && !debug_single_step && !dbg_brk_d)
      |=> exc_kind == CEP_X_NMI;
  endproperty
  a_prio: assert property (p_prio) else $error("nmi did not win");

  property p_sys;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_SYS) |=> (cause_code == CEP_CC_SYS && status_q[CEP_ST_EXL]);
  endproperty
  a_sys: assert property (p_sys) else $error("system_call_instruction cause wrong");

  property p_dbgvec;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_DIB && dbgctl_q[CEP_DC_PRB])
      |=> (exc_vector == CEP_VEC_DBG_PRB && debug_cause == 6'h04);
  endproperty
  a_dbgvec: assert property (p_dbgvec) else $error("debug vector wrong");

  property p_gen;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_LOAD_MISALIGN_FAULT) |=> (exc_vector == $past(exception_base_q) + CEP_GEN_OFS);
  endproperty
  a_gen: assert property (p_gen) else $error("general vector wrong");

  property p_ss;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && !intctl_q[CEP_MULTI_VECTOR_MODE_BIT]) |=> !shadow_set;
  endproperty
  a_ss: assert property (p_ss) else $error("shadow set without multi-vector");

  property p_int;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_INT) |=> (cause_code == CEP_CC_INT
      && status_q[CEP_ST_IPL +: 3] == $past(int_level));
  endproperty
  a_int: assert property (p_int) else $error("interrupt level not recorded");

  property p_debug_interrupt;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && sel_d == CEP_X_DEBUG_INTERRUPT) |=> (debug_cause == 6'h02 && !dbgctl_q[CEP_DC_BRK]);
  endproperty
  a_debug_interrupt: assert property (p_debug_interrupt) else $error("debug interrupt wrong");

endmodule

// [testbench/cep_core_model.sv]
// Core model mapping request bits onto the exception request lines
`timescale 1ns/1ps
module cep_core_model
  import cep_pkg::*;
(
  // Requests indexed by exception kind
  input  wire logic [12:0] req,
  // Source lines towards the prioritizer
  output logic             master_clear_input,
  output logic             soft_reset_req,
  output logic             debug_single_step,
  output logic             nmi_req,
  output logic             int_req,
  output logic             debug_instruction_break,
  output logic             load_misalign_fault,
  output logic             fetch_bus_fault,
  output logic             debug_breakpoint_instruction,
  output logic             system_call_instruction,
  output logic             break_fault
);
  // Every source may be raised in the same cycle as any other
  assign master_clear_input           = req[CEP_X_RST];
  assign soft_reset_req               = req[CEP_X_SRST];
  assign debug_single_step            = req[CEP_X_DSS];
  assign nmi_req                      = req[CEP_X_NMI];
  assign int_req                      = req[CEP_X_INT];
  assign debug_instruction_break      = req[CEP_X_DIB];
  assign load_misalign_fault          = req[CEP_X_LOAD_MISALIGN_FAULT];
  assign fetch_bus_fault              = req[CEP_X_IBE];
  assign debug_breakpoint_instruction = req[CEP_X_DBP];
  assign system_call_instruction      = req[CEP_X_SYS];
  assign break_fault                  = req[CEP_X_BRK];
endmodule

// [testbench/tb.sv]
// Self-checking testbench for the exception prioritizer
`timescale 1ns/1ps
module tb
  import cep_pkg::*;
;
  // Bench state
  logic        clk_sys, rstn, clk_en;
  logic [12:0] req;
  logic [31:0] d;
  int          fail_count, total_checks;
  // Source lines
  logic master_clear_input, soft_reset_req, debug_single_step, nmi_req, int_req;
  logic debug_instruction_break, load_misalign_fault, fetch_bus_fault;
  logic debug_breakpoint_instruction, system_call_instruction, break_fault;
  // Other design pins
  logic [2:0]  int_level, ext_irq_pin, ext_irq_edge, e;
  logic [3:0]  reg_addr, exc_kind;
  logic [31:0] reg_wdata, reg_rdata, exc_vector;
  logic        reg_wr, reg_rd, exc_take, shadow_set, irq;
  logic [4:0]  cause_code;
  logic [5:0]  debug_cause;
  cep_core_model i_core (
    .req, .master_clear_input, .soft_reset_req, .debug_single_step, .nmi_req, .int_req,
    .debug_instruction_break, .load_misalign_fault, .fetch_bus_fault,
    .debug_breakpoint_instruction, .system_call_instruction, .break_fault
  );
  cep_prioritizer i_dut (
    .clk_sys, .rstn, .clk_en, .master_clear_input, .soft_reset_req, .debug_single_step,
    .nmi_req, .int_req, .int_level, .debug_instruction_break, .load_misalign_fault,
    .fetch_bus_fault, .debug_breakpoint_instruction, .system_call_instruction, .break_fault,
    .ext_irq_pin, .exc_take, .exc_vector, .cause_code, .exc_kind, .debug_cause, .shadow_set,
    .ext_irq_edge, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic wait_take;
    for (int i = 0; i < 8 && exc_take !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] vec(input int k, input logic p);
    case (k)
      CEP_X_DSS, CEP_X_DEBUG_INTERRUPT, CEP_X_DIB, CEP_X_DBP: return p ? CEP_VEC_DBG_PRB : CEP_VEC_DBG_NOPRB;
      CEP_X_RST, CEP_X_SRST, CEP_X_NMI:            return CEP_VEC_BOOT;
      default:                                     return CEP_EXCEPTION_BASE_RST + CEP_GEN_OFS;
    endcase
  endfunction
  function automatic logic [31:0] stm(input int k);
    case (k)
      CEP_X_RST:                                   return 32'h0040_0004;
      CEP_X_SRST:                                  return 32'h0050_0004;
      CEP_X_NMI:                                   return 32'h0048_0004;
      CEP_X_INT:                                   return 32'h0000_1400;
      CEP_X_LOAD_MISALIGN_FAULT, CEP_X_IBE, CEP_X_SYS, CEP_X_BRK: return 32'h0000_0002;
      default:                                     return 32'h0;
    endcase
  endfunction
  function automatic logic [5:0] cc(input int k);
    case (k)
      CEP_X_INT:  return {1'b1, CEP_CC_INT};
      CEP_X_LOAD_MISALIGN_FAULT: return {1'b1, CEP_CC_LOAD_MISALIGN_FAULT};
      CEP_X_IBE:  return {1'b1, CEP_CC_IBE};
      CEP_X_SYS:  return {1'b1, CEP_CC_SYS};
      CEP_X_BRK:  return {1'b1, CEP_CC_BRK};
      default:    return 6'h0;
    endcase
  endfunction
  function automatic logic [5:0] dc(input int k);
    case (k)
      CEP_X_DSS:  return 6'h1;
      CEP_X_DEBUG_INTERRUPT: return 6'h2;
      CEP_X_DIB:  return 6'h4;
      CEP_X_DBP:  return 6'h8;
      default:    return 6'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic take(input logic [12:0] m, input int k, input logic p);
    logic [5:0] c;
    wr(CEP_A_STATUS, 32'h0);
    @(posedge clk_sys);
    req <= m;
    @(posedge clk_sys);
    req <= '0;
    #1;
    c = cc(k);
    chk("take", 32'h1, {31'h0, exc_take});
    chk("kind", 32'(k), {28'h0, exc_kind});
    if (k != CEP_X_INT)
      chk("vector", vec(k, p), exc_vector);
    chk("debug cause", {26'h0, dc(k)}, {26'h0, debug_cause});
    if (c[5])
      chk("cause code", {27'h0, c[4:0]}, {27'h0, cause_code});
    rd(CEP_A_STATUS, d);
    chk("status", stm(k), d);
    if (c[5])
    begin
      rd(CEP_A_CAUSE, d);
      chk("cause field", {27'h0, c[4:0]}, {27'h0, d[6:2]});
    end
  endtask
  task automatic sh(input logic [2:0] l, input logic x);
    @(posedge clk_sys);
    int_level <= l;
    req       <= 13'h1 << CEP_X_INT;
    @(posedge clk_sys);
    req       <= '0;
    #1;
    chk("shadow set", {31'h0, x}, {31'h0, shadow_set});
  endtask
  task automatic edges(input logic [2:0] v, input logic [2:0] x);
    @(posedge clk_sys);
    ext_irq_pin <= v;
    e = '0;
    repeat (6)
    begin
      @(posedge clk_sys);
      #1;
      e |= ext_irq_edge;
    end
    chk("edges", {29'h0, x}, {29'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    fail_count   = 0;
    total_checks = 0;
    rstn         = 1'b0;
    clk_en       = 1'b1;
    req          = '0;
    int_level    = 3'h5;
    ext_irq_pin  = 3'h0;
    reg_addr     = 4'h0;
    reg_wdata    = 32'h0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk("reset vector", CEP_VEC_BOOT, exc_vector);
    rd(CEP_A_STATUS, d);
    chk("reset status", 32'h0040_0004, d);
    rd(CEP_A_PRIORITY_SHADOW_SELECT, d);
    chk("shadow reset", 32'h0, d);
    rd(4'hf, d);
    chk("unmapped read", 32'h0, d);
    for (int p = 0; p < 2; p++)
      for (int k = CEP_X_SRST; k <= CEP_X_BRK; k++)
      begin
        wr(CEP_A_DBGCTL, 32'(p) << CEP_DC_PRB);
        if (k != CEP_X_DEBUG_INTERRUPT)
          take(13'h1fff << k, k, p[0]);
      end
    wr(CEP_A_DBGCTL, 32'h0000_9000);
    wait_take();
    chk("break kind", 32'(CEP_X_DEBUG_INTERRUPT), {28'h0, exc_kind});
    chk("break vector", CEP_VEC_DBG_PRB, exc_vector);
    chk("break cause", 32'h2, {26'h0, debug_cause});
    rd(CEP_A_DBGCTL, d);
    chk("break clear", 32'h0, {31'h0, d[CEP_DC_BRK]});
    wr(CEP_A_PRIORITY_SHADOW_SELECT, 32'h1200_0010);
    rd(CEP_A_PRIORITY_SHADOW_SELECT, d);
    chk("shadow fields", 32'h1200_0010, d);
    sh(3'h7, 1'b0);
    wr(CEP_A_INTCTL, 32'h0000_1000);
    sh(3'h7, 1'b1);
    sh(3'h6, 1'b0);
    sh(3'h1, 1'b1);
    sh(3'h3, 1'b0);
    wr(CEP_A_INTCTL, 32'h0000_1005);
    wr(CEP_A_IRQMSK, 32'h7);
    edges(3'h7, 3'h5);
    edges(3'h0, 3'h2);
    rd(CEP_A_IRQST, d);
    chk("irq status", 32'h7, {29'h0, d[2:0]});
    chk("irq high", 32'h1, {31'h0, irq});
    wr(CEP_A_IRQMSK, 32'h0);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(CEP_A_IRQMSK, 32'h7);
    wr(CEP_A_IRQST, 32'h7);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge clk_sys);
    clk_en <= 1'b0;
    req    <= 13'h1 << CEP_X_SYS;
    repeat (2) @(posedge clk_sys);
    clk_en <= 1'b1;
    #1;
    chk("frozen take", 32'h0, {31'h0, exc_take});
    @(posedge clk_sys);
    req <= '0;
    #1;
    chk("enabled kind", 32'(CEP_X_SYS), {28'h0, exc_kind});
    @(posedge clk_sys);
    #1;
    chk("take drops", 32'h0, {31'h0, exc_take});
    @(posedge clk_sys);
    req <= 13'h1 << CEP_X_RST;
    wait_take();
    req <= '0;
    chk("clear kind", 32'(CEP_X_RST), {28'h0, exc_kind});
    chk("clear vector", CEP_VEC_BOOT, exc_vector);
    repeat (4) @(posedge clk_sys);
    rd(CEP_A_STATUS, d);
    chk("clear status", stm(CEP_X_RST), d & stm(CEP_X_RST));
    report_and_stop();
  end
endmodule
